// ### rtl/opstate_pkg.sv
// Purpose: Shared constants and types for the operating-state sequencer.
// Assumes: 20 MHz mclk; lamp order run (top), halt, error (bottom).
// Notes:   Long counts except the start-up lamp steps are top-level parameters fed from these defaults.
package opstate_pkg;

  localparam int unsigned CLK_HZ = 20000000;

  // Battery window in millivolts
  localparam logic [11:0] BATT_LOW_MV  = 12'h8FC;  // 2300
  localparam logic [11:0] BATT_HIGH_MV = 12'hDAC;  // 3500

  // Start-up timeline in milliseconds
  localparam int unsigned T_SELFTEST_MS = 1000;
  localparam int unsigned T_STEP1_MS    = 1300;
  localparam int unsigned T_STEP2_MS    = 1400;
  localparam int unsigned T_STEP3_MS    = 1500;
  localparam int unsigned T_STEP4_MS    = 2500;
  localparam int unsigned T_STEP5_MS    = 3500;
  localparam int unsigned T_START_MS    = 4000;
  localparam int unsigned T_REPROG_MS   = 30000;
  localparam int unsigned T_FLASH_MS    = 250;

  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  function automatic int unsigned ms_to_cyc(input int unsigned ms);
    ms_to_cyc = ms * CYC_PER_MS;
  endfunction

  localparam int unsigned CYC_STEP1  = ms_to_cyc(T_STEP1_MS);
  localparam int unsigned CYC_STEP2  = ms_to_cyc(T_STEP2_MS);
  localparam int unsigned CYC_STEP3  = ms_to_cyc(T_STEP3_MS);
  localparam int unsigned CYC_STEP4  = ms_to_cyc(T_STEP4_MS);
  localparam int unsigned CYC_STEP5  = ms_to_cyc(T_STEP5_MS);
  localparam int unsigned CYC_START  = ms_to_cyc(T_START_MS);
  localparam int unsigned CYC_REPROG = ms_to_cyc(T_REPROG_MS);
  localparam int unsigned CYC_FLASH  = ms_to_cyc(T_FLASH_MS);

  // Register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATE  = 4'h1;
  localparam logic [3:0] ADDR_IRQ_ST = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MK = 4'h3;
  localparam logic [3:0] ADDR_BATT   = 4'h4;

  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'h00;

  // Interrupt status bit positions
  localparam int unsigned EV_BATT  = 0;
  localparam int unsigned EV_HALT  = 1;
  localparam int unsigned EV_ERROR = 2;
  localparam int unsigned EV_STOP  = 3;
  localparam int unsigned EV_RUN   = 4;
  localparam int unsigned EV_BITS  = 5;

  typedef enum logic [3:0] {
    ST_RESET, ST_STARTUP, ST_RUN, ST_CONDITIONAL_RUN_STATE, ST_STOP, ST_HALT,
    ST_ERROR, ST_NO_FW, ST_FW_LOAD, ST_REPROG
  } op_state_e;

  typedef struct packed {
    logic run;
    logic halt;
    logic error;
  } lamps_s;

  typedef struct packed {
    logic debug_attached;
    logic tool_stop;
    logic tool_run;
    logic bp_armed;
    logic bp_hit;
  } tool_req_s;

  typedef struct packed {
    logic halt_instr;
    logic prog_fatal;
    logic hw_error;
    logic diag_error;
    logic handler_present;
  } exec_ev_s;

endpackage

// ### rtl/lamp_pattern.sv
// Purpose: Chooses the lamp image for the current operating state.
// Assumes: Startup timer and flash phase come from the sequencer.
// Notes:   Purely combinational; the top registers the lamps.
`timescale 1ns/1ps
`default_nettype none
module lamp_pattern (
  input  wire opstate_pkg::op_state_e state,
  input  wire logic [31:0]            boot_cnt,
  input  wire logic [1:0]             phase,
  input  wire logic                   err_pending,
  output opstate_pkg::lamps_s         lamps
);

  always_comb begin
    lamps = '0;
    case (state)
      opstate_pkg::ST_RESET: begin
        lamps = '1;
      end
      opstate_pkg::ST_STARTUP: begin
        if (boot_cnt < opstate_pkg::CYC_STEP1) begin
          lamps = '0;
        end else if (boot_cnt < opstate_pkg::CYC_STEP2) begin
          lamps = '{run: 1'b0, halt: 1'b0, error: 1'b1};
        end else if (boot_cnt < opstate_pkg::CYC_STEP3) begin
          lamps = '{run: 1'b0, halt: 1'b1, error: 1'b0};
        end else if (boot_cnt < opstate_pkg::CYC_STEP4) begin
          lamps = '{run: 1'b1, halt: 1'b0, error: 1'b0};
        end else if (boot_cnt < opstate_pkg::CYC_STEP5) begin
          lamps = '{run: 1'b0, halt: 1'b0, error: 1'b1};
        end else begin
          lamps = '0;
        end
      end
      opstate_pkg::ST_RUN, opstate_pkg::ST_CONDITIONAL_RUN_STATE: begin
        lamps = '{run: 1'b1, halt: 1'b0, error: err_pending};
      end
      opstate_pkg::ST_STOP, opstate_pkg::ST_REPROG: begin
        lamps = '{run: 1'b1, halt: 1'b0, error: err_pending};
      end
      opstate_pkg::ST_HALT: begin
        lamps = '{run: 1'b0, halt: 1'b1, error: err_pending};
      end
      opstate_pkg::ST_ERROR: begin
        lamps = '{run: 1'b1, halt: 1'b0, error: 1'b1};
      end
      opstate_pkg::ST_NO_FW: begin
        case (phase)
          2'h0:    lamps = '{run: 1'b1, halt: 1'b0, error: 1'b0};
          2'h1:    lamps = '{run: 1'b0, halt: 1'b1, error: 1'b0};
          2'h2:    lamps = '{run: 1'b0, halt: 1'b0, error: 1'b1};
          default: lamps = '{run: 1'b0, halt: 1'b1, error: 1'b0};
        endcase
      end
      opstate_pkg::ST_FW_LOAD: begin
        case (phase)
          2'h0:    lamps = '{run: 1'b0, halt: 1'b0, error: 1'b1};
          2'h1:    lamps = '{run: 1'b0, halt: 1'b1, error: 1'b0};
          default: lamps = '{run: 1'b1, halt: 1'b0, error: 1'b0};
        endcase
      end
      default: begin
        lamps = '1;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### rtl/opstate_seq.sv
// Purpose: Processor operating-state sequencer with lamps and battery event.
// Assumes: All inputs synchronous to mclk; battery level given in millivolts.
// Notes:   Long timers except the start-up lamp steps are parameters so simulation can shorten them.
//
// What this block does
// - Battery outside 2.3-3.5 V lamps and interrupts
// - Exactly three lamps: run, halt, error
// - Run state executes program, no breakpoint
// - Conditional run stops when breakpoint met
// - Stop on debug power-on or tool stop
// - Halt on switch, instruction, fatal, hardware
// - Unhandled diagnostic error enters error state
// - Reset during self-test and low supply
// - No firmware: lamps sweep up and down
// - Firmware loading: lamps sweep bottom to top
// - Timed power-up lamp sequence until 4.0 s
// - Reprogramming 30 s shows stopped image
`timescale 1ns/1ps
`default_nettype none
module opstate_seq #(
  parameter int unsigned SELFTEST_CYC = opstate_pkg::ms_to_cyc(opstate_pkg::T_SELFTEST_MS),
  parameter int unsigned START_CYC    = opstate_pkg::CYC_START,
  parameter int unsigned REPROG_CYC   = opstate_pkg::CYC_REPROG,
  parameter int unsigned FLASH_CYC    = opstate_pkg::CYC_FLASH
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic                   supply_low,
  input  wire logic [11:0]            batt_mv,
  input  wire logic                   halt_switch,
  input  wire logic                   fw_present,
  input  wire logic                   fw_loading,
  input  wire logic                   fw_updated,
  input  wire opstate_pkg::tool_req_s tool,
  input  wire opstate_pkg::exec_ev_s  exec_ev,
  input  wire logic [3:0]             addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output opstate_pkg::lamps_s         lamps_q,
  output logic                        batt_lamp_q,
  output logic                        batt_handler_q,
  output logic                        irq_q,
  output logic [7:0]                  rdata_q
);

  opstate_pkg::op_state_e state_q;
  opstate_pkg::op_state_e state_d;
  opstate_pkg::lamps_s    lamps_d;
  logic [31:0]            tmr_q;
  logic [31:0]            flash_q;
  logic [1:0]             phase_q;
  logic                   err_pend_q;
  logic                   batt_bad;
  logic                   batt_bad_q;
  logic [7:0]             ctrl_q;
  logic [opstate_pkg::EV_BITS-1:0] ist_q;
  logic [opstate_pkg::EV_BITS-1:0] imask_q;
  logic [opstate_pkg::EV_BITS-1:0] ev;
  logic                   halt_cause;
  logic                   err_cause;

  assign batt_bad = (batt_mv < opstate_pkg::BATT_LOW_MV) || (batt_mv > opstate_pkg::BATT_HIGH_MV);

  assign halt_cause = halt_switch | exec_ev.halt_instr | exec_ev.prog_fatal | exec_ev.hw_error |
                      ctrl_q[0];
  assign err_cause = exec_ev.diag_error & ~exec_ev.handler_present;

  always_comb begin
    state_d = state_q;
    case (state_q)
      opstate_pkg::ST_RESET: begin
        if (tmr_q >= SELFTEST_CYC - 1) begin
          state_d = opstate_pkg::ST_STARTUP;
        end
      end
      opstate_pkg::ST_STARTUP: begin
        if (tmr_q >= START_CYC - 1) begin
          if (!fw_present) begin
            state_d = opstate_pkg::ST_NO_FW;
          end else if (fw_updated) begin
            state_d = opstate_pkg::ST_REPROG;
          end else if (halt_cause) begin
            state_d = opstate_pkg::ST_HALT;
          end else if (tool.debug_attached) begin
            state_d = opstate_pkg::ST_STOP;
          end else begin
            state_d = opstate_pkg::ST_RUN;
          end
        end
      end
      opstate_pkg::ST_RUN, opstate_pkg::ST_CONDITIONAL_RUN_STATE: begin
        if (halt_cause) begin
          state_d = opstate_pkg::ST_HALT;
        end else if (err_cause) begin
          state_d = opstate_pkg::ST_ERROR;
        end else if (tool.tool_stop) begin
          state_d = opstate_pkg::ST_STOP;
        end else if (state_q == opstate_pkg::ST_CONDITIONAL_RUN_STATE && tool.bp_hit) begin
          state_d = opstate_pkg::ST_STOP;
        end else if (state_q == opstate_pkg::ST_RUN && tool.bp_armed) begin
          state_d = opstate_pkg::ST_CONDITIONAL_RUN_STATE;
        end
      end
      opstate_pkg::ST_STOP: begin
        if (halt_cause) begin
          state_d = opstate_pkg::ST_HALT;
        end else if (tool.tool_run) begin
          state_d = tool.bp_armed ? opstate_pkg::ST_CONDITIONAL_RUN_STATE : opstate_pkg::ST_RUN;
        end
      end
      opstate_pkg::ST_ERROR: begin
        if (halt_cause) begin
          state_d = opstate_pkg::ST_HALT;
        end else if (tool.tool_stop) begin
          state_d = opstate_pkg::ST_STOP;
        end
      end
      opstate_pkg::ST_HALT: begin
        if (tool.tool_run && !halt_cause) begin
          state_d = opstate_pkg::ST_RUN;
        end
      end
      opstate_pkg::ST_NO_FW: begin
        if (fw_loading) begin
          state_d = opstate_pkg::ST_FW_LOAD;
        end
      end
      opstate_pkg::ST_FW_LOAD: begin
        if (!fw_loading) begin
          state_d = opstate_pkg::ST_REPROG;
        end
      end
      opstate_pkg::ST_REPROG: begin
        if (tmr_q >= REPROG_CYC - 1) begin
          state_d = opstate_pkg::ST_STOP;
        end
      end
      default: begin
        state_d = opstate_pkg::ST_RESET;
      end
    endcase
    if (supply_low) begin
      state_d = opstate_pkg::ST_RESET;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= opstate_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Timer restarts on every state change
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tmr_q <= 32'h0000_0000;
    end else if (state_d != state_q) begin
      tmr_q <= 32'h0000_0000;
    end else if (tmr_q != 32'hFFFF_FFFF) begin
      tmr_q <= tmr_q + 32'h0000_0001;
    end
  end

  // Flash phase for the sweep patterns; up/down uses four steps
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flash_q <= 32'h0000_0000;
      phase_q <= 2'h0;
    end else if (flash_q >= FLASH_CYC - 1) begin
      flash_q <= 32'h0000_0000;
      if (state_q == opstate_pkg::ST_FW_LOAD && phase_q == 2'h2) begin
        phase_q <= 2'h0;
      end else begin
        phase_q <= phase_q + 2'h1;
      end
    end else begin
      flash_q <= flash_q + 32'h0000_0001;
    end
  end

  // Pending error shown on lamp in stop and halt; cleared on reset state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      err_pend_q <= 1'b0;
    end else if (state_q == opstate_pkg::ST_RESET) begin
      err_pend_q <= 1'b0;
    end else if (err_cause) begin
      err_pend_q <= 1'b1;
    end
  end

  lamp_pattern u_lamps (
    .state       (state_q),
    .boot_cnt    (tmr_q),
    .phase       (phase_q),
    .err_pending (err_pend_q),
    .lamps       (lamps_d)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lamps_q <= '1;
    end else begin
      lamps_q <= lamps_d;
    end
  end

  // battery lamp and handler pulse on entry to fault
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      batt_bad_q     <= 1'b0;
      batt_lamp_q    <= 1'b0;
      batt_handler_q <= 1'b0;
    end else begin
      batt_bad_q     <= batt_bad;
      batt_lamp_q    <= batt_bad;
      batt_handler_q <= batt_bad & ~batt_bad_q;
    end
  end

  always_comb begin
    ev = '0;
    ev[opstate_pkg::EV_BATT]  = batt_bad & ~batt_bad_q;
    ev[opstate_pkg::EV_HALT]  = (state_d == opstate_pkg::ST_HALT) &&
                                (state_q != opstate_pkg::ST_HALT);
    ev[opstate_pkg::EV_ERROR] = (state_d == opstate_pkg::ST_ERROR) &&
                                (state_q != opstate_pkg::ST_ERROR);
    ev[opstate_pkg::EV_STOP]  = (state_d == opstate_pkg::ST_STOP) &&
                                (state_q != opstate_pkg::ST_STOP);
    ev[opstate_pkg::EV_RUN]   = (state_d == opstate_pkg::ST_RUN) &&
                                (state_q != opstate_pkg::ST_RUN);
  end

  // Sticky status; a new event wins over a same-cycle clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ist_q <= '0;
    end else if (wr && addr == opstate_pkg::ADDR_IRQ_ST) begin
      ist_q <= (ist_q & ~wdata[opstate_pkg::EV_BITS-1:0]) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      imask_q <= opstate_pkg::MASK_RESET[opstate_pkg::EV_BITS-1:0];
      ctrl_q  <= opstate_pkg::CTRL_RESET;
    end else if (wr) begin
      if (addr == opstate_pkg::ADDR_IRQ_MK) begin
        imask_q <= wdata[opstate_pkg::EV_BITS-1:0];
      end
      if (addr == opstate_pkg::ADDR_CTRL) begin
        ctrl_q <= {7'h00, wdata[0]};
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ist_q & imask_q);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        opstate_pkg::ADDR_CTRL:   rdata_q <= ctrl_q;
        opstate_pkg::ADDR_STATE:  rdata_q <= {1'b0, lamps_q, state_q};
        opstate_pkg::ADDR_IRQ_ST: rdata_q <= {3'h0, ist_q};
        opstate_pkg::ADDR_IRQ_MK: rdata_q <= {3'h0, imask_q};
        opstate_pkg::ADDR_BATT:   rdata_q <= {7'h00, batt_bad_q};
        default:                  rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  chk_batt_lamp_follows: assert property (@(posedge mclk) disable iff (!rstn)
    batt_bad |=> batt_lamp_q) else $error("battery lamp not lit");
  chk_one_lamp_image: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == opstate_pkg::ST_HALT |=> !lamps_q.run && lamps_q.halt)
    else $error("halt lamp image wrong");
  chk_conditional_run_state_stop: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == opstate_pkg::ST_CONDITIONAL_RUN_STATE && tool.bp_hit && !halt_cause && !err_cause
    && !supply_low |=> state_q == opstate_pkg::ST_STOP)
    else $error("breakpoint did not stop");
  chk_tool_stop: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == opstate_pkg::ST_RUN && tool.tool_stop && !halt_cause && !err_cause
    && !supply_low |=> state_q == opstate_pkg::ST_STOP) else $error("tool stop ignored");
  chk_halt_entry: assert property (@(posedge mclk) disable iff (!rstn)
    (state_q == opstate_pkg::ST_RUN || state_q == opstate_pkg::ST_STOP) && halt_cause
    && !supply_low |=> state_q == opstate_pkg::ST_HALT) else $error("halt not taken");
  chk_error_entry: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == opstate_pkg::ST_RUN && err_cause && !halt_cause && !supply_low
    |=> state_q == opstate_pkg::ST_ERROR ##1 lamps_q.error) else $error("error state missed");
  chk_low_supply: assert property (@(posedge mclk) disable iff (!rstn)
    supply_low |=> state_q == opstate_pkg::ST_RESET ##1 lamps_q == '1)
    else $error("low supply not reset");
  chk_stop_image: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == opstate_pkg::ST_STOP |=> lamps_q.run && !lamps_q.halt)
    else $error("stop lamp image wrong");
  chk_load_sweep: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == opstate_pkg::ST_FW_LOAD |=> $onehot(lamps_q)) else $error("load sweep wrong");
  chk_nofw_sweep: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == opstate_pkg::ST_NO_FW |=> $onehot(lamps_q)) else $error("no fw sweep wrong");

  cov_batt_fault: cover property (@(posedge mclk) disable iff (!rstn) batt_handler_q);
  cov_reach_run: cover property (@(posedge mclk) disable iff (!rstn)
    state_q == opstate_pkg::ST_RUN);
  cov_cond_stop: cover property (@(posedge mclk) disable iff (!rstn)
    state_q == opstate_pkg::ST_CONDITIONAL_RUN_STATE ##1 state_q == opstate_pkg::ST_STOP);
  cov_irq: cover property (@(posedge mclk) disable iff (!rstn) irq_q);

endmodule
`default_nettype wire

// ### tb/ctl_partner.sv
// Purpose: Model of the programming tool, run/halt switch and supply monitor.
// Assumes: Every change is made just after a rising mclk edge.
// Notes:   Tool requests other than debug attach are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module ctl_partner (
  input  wire logic               mclk,
  output opstate_pkg::tool_req_s  tool,
  output logic                    halt_switch,
  output logic                    supply_low,
  output logic [11:0]             batt_mv
);
  logic dbg;

  initial begin
    tool        = '0;
    halt_switch = 1'b0;
    supply_low  = 1'b0;
    batt_mv     = 12'hBB8;
    dbg         = 1'b0;
  end

  task automatic tool_pulse(input logic [4:0] v);
    @(posedge mclk) tool <= v | {dbg, 4'h0};
    @(posedge mclk) tool <= {dbg, 4'h0};
  endtask

  task automatic set_dbg(input logic v);
    @(posedge mclk) tool <= {v, 4'h0};
    dbg = v;
  endtask

  task automatic set_switch(input logic v);
    @(posedge mclk) halt_switch <= v;
  endtask

  task automatic set_supply(input logic v);
    @(posedge mclk) supply_low <= v;
  endtask

  task automatic set_batt(input logic [11:0] v);
    @(posedge mclk) batt_mv <= v;
  endtask
endmodule
`default_nettype wire

// ### tb/test_opstate_seq.sv
// Purpose: Self-checking bench for the operating-state sequencer.
// Assumes: Long timers shortened by parameters; start-up steps not reached.
// Notes:   State is observed through the state register, lamps at the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module test_opstate_seq;
  localparam int unsigned SEL = 20;
  localparam int unsigned STC = 100;
  localparam int unsigned RPC = 50;
  localparam int unsigned FLC = 4;
  localparam logic [11:0] CORNER [4] = '{12'h8FB, 12'h8FC, 12'hDAC, 12'hDAD};

  logic                   mclk = 1'b0;
  logic                   rstn = 1'b0;
  logic                   fw_present = 1'b1;
  logic                   fw_loading = 1'b0;
  logic                   fw_updated = 1'b0;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic [3:0]             addr = 4'h0;
  logic [7:0]             wdata = 8'h00;
  opstate_pkg::exec_ev_s  exec_ev = '0;
  opstate_pkg::tool_req_s tool;
  logic                   supply_low;
  logic                   halt_switch;
  logic [11:0]            batt_mv;
  opstate_pkg::lamps_s    lamps_q;
  logic                   batt_lamp_q;
  logic                   batt_handler_q;
  logic                   irq_q;
  logic [7:0]             rdata_q;
  int                     err_count = 0;
  int                     cmp_count = 0;

  always #25 mclk = ~mclk;

  ctl_partner i_ctl_partner (.mclk(mclk), .tool(tool), .halt_switch(halt_switch),
    .supply_low(supply_low), .batt_mv(batt_mv));

  opstate_seq #(.SELFTEST_CYC(SEL), .START_CYC(STC), .REPROG_CYC(RPC), .FLASH_CYC(FLC))
  i_opstate_seq (.mclk(mclk), .rstn(rstn), .supply_low(supply_low), .batt_mv(batt_mv),
    .halt_switch(halt_switch), .fw_present(fw_present), .fw_loading(fw_loading),
    .fw_updated(fw_updated), .tool(tool), .exec_ev(exec_ev), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .lamps_q(lamps_q), .batt_lamp_q(batt_lamp_q),
    .batt_handler_q(batt_handler_q), .irq_q(irq_q), .rdata_q(rdata_q));

  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic bad(input logic [11:0] v);
    return v < opstate_pkg::BATT_LOW_MV || v > opstate_pkg::BATT_HIGH_MV;
  endfunction

  // Next lamp image of a sweep; edge is the last end lamp seen when bouncing
  function automatic logic [2:0] exp_next(input bit up, input logic [2:0] cur,
                                          input logic [2:0] edge_l);
    if (up) return (cur == 3'b001) ? 3'b010 : (cur == 3'b010) ? 3'b100 : 3'b001;
    if (cur != 3'b010) return 3'b010;
    return (edge_l == 3'b100) ? 3'b001 : 3'b100;
  endfunction

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata_q;
  endtask

  task automatic wait_state(input logic [3:0] s, input int lim);
    logic [7:0] d;
    int n;
    n = 0;
    rd_reg(opstate_pkg::ADDR_STATE, d);
    while (d[3:0] !== s && n < lim) begin
      rd_reg(opstate_pkg::ADDR_STATE, d);
      n++;
    end
    `CHK("state", s, d[3:0])
    if (d[3:0] !== s) close_out();
  endtask

  task automatic ev_pulse(input logic [4:0] v);
    @(posedge mclk) exec_ev <= v;
    @(posedge mclk) exec_ev <= {4'h0, v[0]};
  endtask

  // First change may leave a non-sweep image, so checks start after it
  task automatic sweep(input bit up);
    logic [2:0] prev;
    logic [2:0] edge_l;
    int run;
    int seen;
    prev = lamps_q;
    edge_l = 3'b000;
    run = 0;
    seen = 0;
    repeat (FLC * 12) begin
      @(posedge mclk);
      #1 run++;
      if (lamps_q !== prev) begin
        if (seen > 0) `CHK("dwell", FLC, run)
        if (seen > 0 && (up || prev != 3'b010 || edge_l != 3'b000))
          `CHK("sweep", exp_next(up, prev, edge_l), lamps_q)
        if (lamps_q !== 3'b010) edge_l = lamps_q;
        prev = lamps_q;
        run = 0;
        seen++;
      end
    end
    `CHK("sweep_steps", 1'b1, seen >= 4)
  endtask

  initial begin
    logic [11:0] v;
    logic pb;
    logic [7:0] d;
    int j;
    void'($urandom(4));
    repeat (4) @(posedge mclk);
    #1 `CHK("reset_lamps", 3'b111, lamps_q)
    @(posedge mclk) rstn <= 1'b1;
    wait_state(4'h0, 2);
    wait_state(4'h1, SEL);
    `CHK("startup_lamps", 3'b000, lamps_q)
    wait_state(4'h2, STC);
    `CHK("run_lamps", 3'b100, lamps_q)
    i_ctl_partner.tool_pulse(5'h02);
    wait_state(4'h3, 4);
    i_ctl_partner.tool_pulse(5'h01);
    wait_state(4'h4, 4);
    `CHK("stop_lamps", 3'b100, lamps_q)
    j = $urandom_range(4, 0);
    for (int k = 0; k < 5; k++) begin
      case ((j + k) % 5)
        0: i_ctl_partner.set_switch(1'b1);
        1: ev_pulse(5'h10);
        2: ev_pulse(5'h08);
        3: ev_pulse(5'h04);
        default: wr_reg(opstate_pkg::ADDR_CTRL, 8'h01);
      endcase
      wait_state(4'h5, 4);
      `CHK("halt_lamps", 3'b010, lamps_q)
      i_ctl_partner.set_switch(1'b0);
      wr_reg(opstate_pkg::ADDR_CTRL, 8'h00);
      i_ctl_partner.tool_pulse(5'h04);
      wait_state(4'h2, 4);
    end
    rd_reg(opstate_pkg::ADDR_IRQ_ST, d);
    `CHK("irq_events", 8'h1A, d)
    i_ctl_partner.tool_pulse(5'h08);
    wait_state(4'h4, 4);
    ev_pulse(5'h10);
    wait_state(4'h5, 4);
    i_ctl_partner.tool_pulse(5'h04);
    wait_state(4'h2, 4);
    ev_pulse(5'h03);
    repeat (4) @(posedge mclk);
    wait_state(4'h2, 0);
    ev_pulse(5'h12);
    wait_state(4'h5, 4);
    i_ctl_partner.tool_pulse(5'h04);
    wait_state(4'h2, 4);
    ev_pulse(5'h02);
    wait_state(4'h6, 4);
    `CHK("error_lamps", 3'b101, lamps_q)
    ev_pulse(5'h10);
    wait_state(4'h5, 4);
    `CHK("halt_pending", 3'b011, lamps_q)
    fork
      i_ctl_partner.set_supply(1'b1);
      ev_pulse(5'h10);
    join
    wait_state(4'h0, 4);
    `CHK("low_supply_lamps", 3'b111, lamps_q)
    fw_present <= 1'b0;
    i_ctl_partner.set_supply(1'b0);
    wait_state(4'h7, SEL + STC);
    sweep(1'b0);
    fw_loading <= 1'b1;
    wait_state(4'h8, 4);
    sweep(1'b1);
    fw_loading <= 1'b0;
    wait_state(4'h9, 4);
    `CHK("reprog_lamps", 3'b100, lamps_q)
    repeat (RPC / 2) @(posedge mclk);
    wait_state(4'h9, 0);
    wait_state(4'h4, RPC);
    pb = 1'b0;
    for (int k = 0; k < 40; k++) begin
      v = (k < 4) ? CORNER[k] : 12'($urandom_range(3900, 1900));
      i_ctl_partner.set_batt(v);
      @(posedge mclk);
      #1 `CHK("batt_lamp", bad(v), batt_lamp_q)
      `CHK("batt_handler", bad(v) && !pb, batt_handler_q)
      pb = bad(v);
    end
    i_ctl_partner.set_batt(12'hBB8);
    wr_reg(opstate_pkg::ADDR_IRQ_MK, 8'h00);
    wr_reg(opstate_pkg::ADDR_IRQ_ST, 8'h1F);
    i_ctl_partner.set_batt(12'h7D0);
    repeat (3) @(posedge mclk);
    #1 `CHK("irq_masked", 1'b0, irq_q)
    rd_reg(opstate_pkg::ADDR_BATT, d);
    `CHK("batt_reg", 1'b1, d[0])
    wr_reg(opstate_pkg::ADDR_IRQ_MK, 8'h01);
    @(posedge mclk);
    #1 `CHK("irq_on", 1'b1, irq_q)
    i_ctl_partner.set_batt(12'hBB8);
    wr_reg(opstate_pkg::ADDR_IRQ_ST, 8'h01);
    @(posedge mclk);
    #1 `CHK("irq_cleared", 1'b0, irq_q)
    rd_reg(4'hF, d);
    `CHK("unmapped", 8'h00, d)
    i_ctl_partner.set_dbg(1'b1);
    fw_present <= 1'b1;
    i_ctl_partner.set_supply(1'b1);
    repeat (3) @(posedge mclk);
    i_ctl_partner.set_supply(1'b0);
    wait_state(4'h0, 4);
    wait_state(4'h4, SEL + STC);
    fw_updated <= 1'b1;
    i_ctl_partner.set_supply(1'b1);
    i_ctl_partner.set_supply(1'b0);
    wait_state(4'h9, SEL + STC);
    fw_updated <= 1'b0;
    wait_state(4'h4, RPC);
    close_out();
  end
endmodule
`default_nettype wire
